// ---- core/led_fade_and_level_outputs.v ----
// LED fading, host PWM, analog level and buzzer outputs for eight pins
//
// The register addresses and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
`include "led_fade_regs.vh"

// Summary of operation
// - Duty resolution is 256 steps
// - Eight PWM generators, one per pin
// - Fading pins ramp up on touch, down on release
// - Ramp curve selectable linear or logarithmic
// - Step interval, start and end intensity configurable
// - Auto lighting fades mapped pin on touch
// - Host output bit starts autonomous fade
// - Host PWM mode drives written duty directly
// - Special mode selects buzzer or level output
// - Level output duty follows touched button
// - First level on pin 7, second on 6
// - Button to output mapping and levels configurable
// - Buzzer on pin 5, about 30 ms per touch
// - Proximity without touch gives half intensity
// - Nothing present: LEDs off, level idle
// - Proximity without touch gives proximity level
// - Touched button: LED full, its level shown
// - Reset: pins 0-6 auto fade, 7 level
// - Reset sensitivities 0x02 buttons, 0x07 proximity
// - Attention line flags new touch information
module led_fade_and_level_outputs #(
  parameter TONE_CYC = `TONE_CYC
) (
  input  wire        clk_sys,
  input  wire        rst,
  input  wire [7:0]  addr,
  input  wire [31:0] wdata,
  input  wire        wr,
  input  wire        rd,
  output reg  [31:0] rdata,
  input  wire [7:0]  button_touch,
  input  wire        prox_detect,
  output wire [7:0]  pin_out,
  output wire [7:0]  sens_button,
  output wire [7:0]  sens_prox,
  output wire        host_attention_line
);

  // Configuration registers
  reg  [3:0]  ctrl_q;
  reg  [15:0] mode_q;
  reg  [7:0]  outval_q;
  reg  [23:0] fade_q;
  reg  [7:0]  lvlmap_q;
  reg  [31:0] idle_q;
  reg  [15:0] sens_q;
  reg  [7:0]  host_duty_q [0:7];
  reg  [7:0]  level_q [0:7];
  wire [7:0]  duty [0:7];
  reg  [31:0] rd_mux_d;
  integer     j;

  // Status tracking
  reg  [7:0]  touch_prev_q;
  reg         prox_prev_q;
  reg         attn_q;

  // Timing
  reg  [15:0] tone_cnt_q;
  reg         tone_tick_q;
  reg  [7:0]  fade_cnt_q;
  reg         fade_tick_q;
  reg  [7:0]  pwm_cnt_q;

  // Buzzer
  reg  [2:0]  buz_state_q;
  reg  [8:0]  buz_cnt_q;
  reg         buz_wave_q;

  // Level output duties
  wire [7:0]  lvl_duty [0:1];

  wire        auto_en   = ctrl_q[`C_AUTO];
  wire        log_curve = ctrl_q[`C_LOG];
  wire        triple_en = ctrl_q[`C_TRIPLE];
  wire [7:0]  fade_int  = fade_q[7:0];
  wire [7:0]  int_off   = fade_q[15:8];
  wire [7:0]  int_full  = fade_q[23:16];
  wire        any_touch = |button_touch;
  wire        new_touch = |(button_touch & ~touch_prev_q);
  wire        stat_rd   = rd && (addr == `A_STATUS);
  wire        hduty_wr  = wr && (addr[7:3] == 5'h02);
  wire        level_wr  = wr && (addr[7:3] == 5'h04);

  // Reset table, buzzer phase length and buzzer states
  localparam [63:0]  LVL_RST_ALL = `LEVEL_RST;
  localparam integer BUZ_HALF    = `BUZ_PHASE_T;
  localparam [2:0]   BZ_IDLE     = 3'b001;
  localparam [2:0]   BZ_LOW      = 3'b010;
  localparam [2:0]   BZ_HIGH     = 3'b100;

  assign sens_button         = sens_q[7:0];
  assign sens_prox           = sens_q[15:8];
  assign host_attention_line = attn_q;

  // Register writes
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctrl_q   <= `CTRL_RST;
      mode_q   <= `MODE_RST;
      outval_q <= 8'h00;
      fade_q   <= `FADE_RST;
      lvlmap_q <= `LVLMAP_RST;
      idle_q   <= `IDLE_RST;
      sens_q   <= `SENS_RST;
    end else if (wr) begin
      case (addr)
        `A_CTRL:   ctrl_q   <= wdata[3:0];
        `A_MODE:   mode_q   <= wdata[15:0];
        `A_OUTVAL: outval_q <= wdata[7:0];
        `A_FADE:   fade_q   <= wdata[23:0];
        `A_LVLMAP: lvlmap_q <= wdata[7:0];
        `A_IDLE:   idle_q   <= wdata;
        `A_SENS:   sens_q   <= wdata[15:0];
        default: ;
      endcase
    end
  end

  // Host duty and button level tables
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      for (j = 0; j < 8; j = j + 1) begin
        host_duty_q[j] <= 8'h00;
        level_q[j]     <= LVL_RST_ALL[8 * j +: 8];
      end
    end else if (hduty_wr) begin
      host_duty_q[addr[2:0]] <= wdata[7:0];
    end else if (level_wr) begin
      level_q[addr[2:0]] <= wdata[7:0];
    end
  end

  // Read data, one cycle after the strobe
  always @* begin
    rd_mux_d = 32'h0;
    case (addr)
      `A_CTRL:   rd_mux_d = {28'h0, ctrl_q};
      `A_MODE:   rd_mux_d = {16'h0, mode_q};
      `A_OUTVAL: rd_mux_d = {24'h0, outval_q};
      `A_FADE:   rd_mux_d = {8'h0, fade_q};
      `A_LVLMAP: rd_mux_d = {24'h0, lvlmap_q};
      `A_IDLE:   rd_mux_d = idle_q;
      `A_SENS:   rd_mux_d = {16'h0, sens_q};
      `A_STATUS: rd_mux_d = {22'h0, attn_q, prox_detect, button_touch};
      default: begin
        if (addr[7:3] == 5'h02) begin
          rd_mux_d = {24'h0, host_duty_q[addr[2:0]]};
        end else if (addr[7:3] == 5'h04) begin
          rd_mux_d = {24'h0, level_q[addr[2:0]]};
        end else if (addr[7:3] == 5'h06) begin
          rd_mux_d = {24'h0, duty[addr[2:0]]};
        end
      end
    endcase
  end

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rdata <= 32'h0;
    end else if (rd) begin
      rdata <= rd_mux_d;
    end
  end

  // Attention flag: a change in the same cycle as the read wins
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      touch_prev_q <= 8'h00;
      prox_prev_q  <= 1'b0;
      attn_q       <= 1'b0;
    end else begin
      touch_prev_q <= button_touch;
      prox_prev_q  <= prox_detect;
      if ((button_touch != touch_prev_q) || (prox_detect != prox_prev_q)) begin
        attn_q <= 1'b1;
      end else if (stat_rd) begin
        attn_q <= 1'b0;
      end
    end
  end

  // Tone tick divider and fade step timer
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tone_cnt_q  <= 16'h0;
      tone_tick_q <= 1'b0;
      fade_cnt_q  <= 8'h00;
      fade_tick_q <= 1'b0;
      pwm_cnt_q   <= 8'h00;
    end else begin
      pwm_cnt_q   <= pwm_cnt_q + 8'h01;
      tone_tick_q <= 1'b0;
      fade_tick_q <= 1'b0;
      if (tone_cnt_q == TONE_CYC[15:0] - 16'h1) begin
        tone_cnt_q  <= 16'h0;
        tone_tick_q <= 1'b1;
      end else begin
        tone_cnt_q <= tone_cnt_q + 16'h1;
      end
      if (tone_tick_q) begin
        if (fade_cnt_q >= fade_int) begin
          fade_cnt_q  <= 8'h00;
          fade_tick_q <= 1'b1;
        end else begin
          fade_cnt_q <= fade_cnt_q + 8'h01;
        end
      end
    end
  end

  // Buzzer: low tone phase then high tone phase, once per new touch
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      buz_state_q <= BZ_IDLE;
      buz_cnt_q   <= 9'h0;
      buz_wave_q  <= 1'b0;
    end else if (new_touch && ctrl_q[`C_BUZ]) begin
      buz_state_q <= BZ_LOW;
      buz_cnt_q   <= 9'h0;
      buz_wave_q  <= 1'b0;
    end else if (tone_tick_q) begin
      case (buz_state_q)
        BZ_LOW: begin
          if (buz_cnt_q[0]) begin
            buz_wave_q <= ~buz_wave_q;
          end
          if ({23'h0, buz_cnt_q} == BUZ_HALF - 1) begin
            buz_state_q <= BZ_HIGH;
            buz_cnt_q   <= 9'h0;
          end else begin
            buz_cnt_q <= buz_cnt_q + 9'h1;
          end
        end
        BZ_HIGH: begin
          if ({23'h0, buz_cnt_q} == BUZ_HALF - 1) begin
            buz_state_q <= BZ_IDLE;
            buz_wave_q  <= 1'b0;
          end else begin
            buz_cnt_q  <= buz_cnt_q + 9'h1;
            buz_wave_q <= ~buz_wave_q;
          end
        end
        default: begin
          buz_state_q <= BZ_IDLE;
          buz_cnt_q   <= 9'h0;
        end
      endcase
    end
  end

  // Level outputs: lowest touched mapped button, else proximity, else idle
  genvar k;
  generate
    for (k = 0; k < 2; k = k + 1) begin : g_lvl
      reg [7:0] sel_d;
      reg [7:0] lvl_q;
      integer   b;
      always @* begin
        sel_d = prox_detect ? idle_q[16 + 8 * k +: 8] : idle_q[8 * k +: 8];
        for (b = 7; b >= 0; b = b - 1) begin
          if (button_touch[b] && (lvlmap_q[b] == (k == 1))) begin
            sel_d = level_q[b];
          end
        end
      end
      always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          lvl_q <= 8'hff;
        end else begin
          lvl_q <= sel_d;
        end
      end
      assign lvl_duty[k] = lvl_q;
    end
  endgenerate

  // Per-pin generators
  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1) begin : g_pin
      reg  [7:0] cur_q;
      reg  [7:0] cur_d;
      reg  [7:0] tgt_d;
      reg  [7:0] spec_d;
      reg  [7:0] duty_d;
      reg        pin_q;
      reg        pin_d;
      wire [1:0] mode = mode_q[2 * i +: 2];
      wire       lit  = auto_en ? button_touch[i] : outval_q[i];
      wire [7:0] stp  = log_curve ? {4'h0, cur_q[7:4]} + 8'h01 : 8'h01;
      wire [8:0] up   = {1'b0, cur_q} + {1'b0, stp};
      wire [8:0] dn   = {1'b0, cur_q} - {1'b0, stp};

      always @* begin
        if (lit) begin
          tgt_d = int_full;
        end else if (auto_en && triple_en && prox_detect && !any_touch) begin
          tgt_d = {1'b0, int_full[7:1]};
        end else begin
          tgt_d = int_off;
        end
      end

      always @* begin
        cur_d = cur_q;
        if (fade_tick_q) begin
          if (cur_q < tgt_d) begin
            cur_d = (up[8] || up[7:0] > tgt_d) ? tgt_d : up[7:0];
          end else if (cur_q > tgt_d) begin
            cur_d = (dn[8] || dn[7:0] < tgt_d) ? tgt_d : dn[7:0];
          end
        end
      end

      always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          cur_q <= 8'h00;
        end else begin
          cur_q <= cur_d;
        end
      end

      always @* begin
        if (i == `PIN_LVL1) begin
          spec_d = lvl_duty[0];
        end else if (i == `PIN_LVL2) begin
          spec_d = lvl_duty[1];
        end else begin
          spec_d = 8'h00;
        end
        case (mode)
          `M_FADE: duty_d = cur_q;
          `M_HPWM: duty_d = host_duty_q[i];
          `M_SPEC: duty_d = spec_d;
          default: duty_d = 8'h00;
        endcase
      end

      always @* begin
        if (mode == `M_SPEC && i == `PIN_BUZ) begin
          pin_d = buz_wave_q;
        end else begin
          pin_d = pwm_cnt_q < duty_d;
        end
      end

      always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          pin_q <= 1'b0;
        end else begin
          pin_q <= pin_d;
        end
      end

      assign duty[i]     = duty_d;
      assign pin_out[i]  = pin_q;
    end
  endgenerate

endmodule

// ---- pkg/led_fade_regs.vh ----
// Register offsets, field positions, reset values and timing for the LED fade block
`ifndef LED_FADE_REGS_VH
`define LED_FADE_REGS_VH
// Register word addresses
`define A_CTRL      8'h00
`define A_MODE      8'h01
`define A_OUTVAL    8'h02
`define A_FADE      8'h03
`define A_LVLMAP    8'h04
`define A_IDLE      8'h05
`define A_SENS      8'h06
`define A_STATUS    8'h07
`define A_HDUTY     8'h10
`define A_LEVEL     8'h20
`define A_DUTY      8'h30
// Control fields
`define C_AUTO      0
`define C_LOG       1
`define C_BUZ       2
`define C_TRIPLE    3
// Pin modes, two bits per pin
`define M_FADE      2'h0
`define M_HPWM      2'h1
`define M_SPEC      2'h2
// Reset values
`define CTRL_RST    4'hd
`define MODE_RST    16'h8000
`define FADE_RST    24'hff000f
`define LVLMAP_RST  8'h00
`define IDLE_RST    32'hffffffff
`define SENS_RST    16'h0702
`define LEVEL_RST   64'h00b9a28b745d462e
// Special pin positions
`define PIN_LVL1    7
`define PIN_LVL2    6
`define PIN_BUZ     5
// Timing
`define CLK_MHZ     100
`define TONE_NS     62500
`define BUZ_PHASE_US 15000
`define TONE_CYC    (`TONE_NS * `CLK_MHZ / 1000)
`define BUZ_PHASE_T (`BUZ_PHASE_US * 1000 / `TONE_NS)
`endif

// ---- verif/led_fade_assertions.sv ----
// Port checker for the LED fade block
`timescale 1ns/1ps
module led_fade_chk (
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic [7:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [31:0] rdata,
  input wire logic [7:0]  button_touch,
  input wire logic        prox_detect,
  input wire logic [7:0]  pin_out,
  input wire logic [7:0]  sens_button,
  input wire logic [7:0]  sens_prox,
  input wire logic        host_attention_line
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  property p_sens_rst; $fell(rst) |-> sens_button == 8'h02 && sens_prox == 8'h07; endproperty
  a_sens_rst: assert property (p_sens_rst) else $error("sens reset");
  property p_sens_wr; wr && addr == 8'h06 |=> {sens_prox, sens_button} == $past(wdata[15:0]); endproperty
  a_sens_wr: assert property (p_sens_wr) else $error("sens write");
  property p_hold; !$past(rd) |-> $stable(rdata); endproperty
  a_hold: assert property (p_hold) else $error("rdata moved");
  property p_unmap; rd && addr[7:3] == 5'h01 |=> rdata == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read");
  property p_stat; rd && addr == 8'h07 |=> rdata[8:0] == $past({prox_detect, button_touch}) && rdata[31:10] == 22'h0;
  endproperty
  a_stat: assert property (p_stat) else $error("status read");
  property p_attn; button_touch != $past(button_touch) |=> host_attention_line; endproperty
  a_attn: assert property (p_attn) else $error("attention missing");
  property p_clr;
    (rd && addr == 8'h07 && $stable(button_touch) && $stable(prox_detect))
      ##1 ($stable(button_touch) && $stable(prox_detect))[*2] |-> !host_attention_line;
  endproperty
  a_clr: assert property (p_clr) else $error("attention stuck");
  property p_hduty; wr && addr == 8'h10 ##2 rd && addr == 8'h10 |=> rdata == {24'h0, $past(wdata[7:0], 3)};
  endproperty
  a_hduty: assert property (p_hduty) else $error("host duty");
  c_touch: cover property ($rose(button_touch[1]));
  c_stat: cover property (rd && addr == 8'h07);
  c_buz: cover property ($rose(pin_out[5]));
endmodule

bind led_fade_and_level_outputs led_fade_chk led_fade_chk_i (.clk_sys(clk_sys), .rst(rst), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .button_touch(button_touch), .prox_detect(prox_detect),
  .pin_out(pin_out), .sens_button(sens_button), .sens_prox(sens_prox), .host_attention_line(host_attention_line));

// ---- verif/pin_load.sv ----
// Pin load model: averaging meter and edge counter on one pin
`timescale 1ns/1ps
module pin_load (
  input  wire logic        clk_sys,
  input  wire logic [7:0]  pin_out,
  input  wire logic [2:0]  sel,
  input  wire logic        clr,
  output logic      [15:0] hi_cnt,
  output logic      [15:0] edge_cnt
);
  logic last_q;
  always @(posedge clk_sys) begin
    last_q <= pin_out[sel];
    if (clr) begin
      hi_cnt <= 16'h0;
      edge_cnt <= 16'h0;
    end else begin
      hi_cnt <= hi_cnt + {15'h0, pin_out[sel]};
      edge_cnt <= edge_cnt + {15'h0, pin_out[sel] ^ last_q};
    end
  end
endmodule

// ---- verif/led_fade_and_level_outputs_test.sv ----
// Testbench for the LED fade block
`timescale 1ns/1ps
module led_fade_and_level_outputs_test;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [7:0]  button_touch = 8'h00;
  logic        prox_detect = 1'b0;
  logic [2:0]  sel = 3'h0;
  logic        clr = 1'b0;
  logic [31:0] rdata;
  logic [7:0]  pin_out;
  logic [15:0] hi_cnt;
  logic [15:0] edge_cnt;
  int          err_total = 0;
  int          check_count = 0;
  logic [7:0]  ra [9] = '{8'h00, 8'h01, 8'h03, 8'h05, 8'h06, 8'h20, 8'h26, 8'h27, 8'h08};
  logic [31:0] rv [9] = '{32'hd, 32'h8000, 32'hff000f, 32'hffffffff, 32'h0702, 32'h2e, 32'hb9, 32'h0, 32'h0};
  always #5 clk_sys = ~clk_sys;
  led_fade_and_level_outputs #(.TONE_CYC(4)) led_fade_and_level_outputs_i (.clk_sys(clk_sys), .rst(rst),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .button_touch(button_touch),
    .prox_detect(prox_detect), .pin_out(pin_out), .sens_button(), .sens_prox(), .host_attention_line());
  pin_load pin_load_i (.clk_sys(clk_sys), .pin_out(pin_out), .sel(sel), .clr(clr), .hi_cnt(hi_cnt),
    .edge_cnt(edge_cnt));
  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_sys);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    rd_reg(a, v);
    chk(v, exp);
  endtask
  task automatic wait_duty(input logic [2:0] p, input logic [7:0] exp);
    logic [31:0] v;
    for (int n = 0; n < 2000; n++) begin
      rd_reg(8'h30 + p, v);
      if (v === {24'h0, exp}) break;
      repeat (4) @(posedge clk_sys);
    end
    chk(v, {24'h0, exp});
    if (v !== {24'h0, exp}) close_out();
  endtask
  task automatic measure(input logic [2:0] p, input logic [15:0] exp);
    @(posedge clk_sys);
    sel <= p;
    clr <= 1'b1;
    @(posedge clk_sys);
    clr <= 1'b0;
    repeat (256) @(posedge clk_sys);
    #1 chk({16'h0, hi_cnt}, {16'h0, exp});
  endtask
  initial begin
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    for (int i = 0; i < 9; i++) rd_chk(ra[i], rv[i]);
    $display("test reset done");
    wr_reg(8'h01, 32'h8001);
    wr_reg(8'h10, 32'h40);
    rd_chk(8'h10, 32'h40);
    measure(3'h0, 16'h40);
    measure(3'h7, 16'hff);
    measure(3'h1, 16'h0);
    $display("test host pwm done");
    wr_reg(8'h03, 32'hff0000);
    wr_reg(8'h01, 32'h8000);
    button_touch <= 8'h02;
    wait_duty(3'h1, 8'hff);
    rd_chk(8'h07, 32'h202);
    measure(3'h7, 16'h46);
    rd_chk(8'h30, 32'h0);
    button_touch <= 8'h00;
    wait_duty(3'h1, 8'h00);
    $display("test touch done");
    wr_reg(8'h05, 32'hffc0ffff);
    prox_detect <= 1'b1;
    wait_duty(3'h0, 8'h7f);
    measure(3'h7, 16'hc0);
    prox_detect <= 1'b0;
    wait_duty(3'h0, 8'h00);
    $display("test proximity done");
    wr_reg(8'h04, 32'h08);
    wr_reg(8'h01, 32'ha800);
    measure(3'h5, 16'h0);
    button_touch <= 8'h08;
    repeat (1930) @(posedge clk_sys);
    #1 chk({31'h0, edge_cnt >= 16'd358 && edge_cnt <= 16'd362}, 32'h1);
    measure(3'h6, 16'h74);
    measure(3'h5, 16'h0);
    $display("test level and buzzer done");
    button_touch <= 8'h00;
    wr_reg(8'h00, 32'h0);
    wr_reg(8'h01, 32'h8000);
    wr_reg(8'h02, 32'h10);
    wait_duty(3'h4, 8'hff);
    $display("test host fade done");
    wr_reg(8'h03, 32'hc01000);
    wr_reg(8'h00, 32'h2);
    wr_reg(8'h02, 32'h20);
    repeat (600) @(posedge clk_sys);
    rd_chk(8'h35, 32'hc0);
    rd_chk(8'h34, 32'h10);
    $display("test log fade done");
    close_out();
  end
endmodule
